// >>> verilog/pmaf_pkg.sv
package pmaf_pkg;
    // ******************************************************************
    // command codes and sub-codes
    // ******************************************************************
    localparam logic [7:0] CMD_ALERT_MASK   = 8'h1B;
    localparam logic [7:0] CMD_VOUT_FORMAT  = 8'h20;
    localparam logic [7:0] SUB_MISC_STATUS  = 8'h7F;
    localparam logic [7:0] SUB_VEND_STATUS  = 8'h80;

    // ******************************************************************
    // field layouts and fixed values
    // ******************************************************************
    localparam logic [7:0] MISC_MASK_VALUE  = 8'h01;
    localparam logic [7:0] VEND_MASK_WR     = 8'hCE;
    localparam int         VEND_POR_BIT     = 7;
    localparam int         VEND_SELF_BIT    = 6;
    localparam int         VEND_RESET_BIT   = 3;
    localparam int         VEND_BCX_BIT     = 2;
    localparam int         VEND_SYNC_BIT    = 1;
    localparam int         FMT_REL_BIT      = 7;
    localparam logic [1:0] FMT_LINEAR       = 2'h0;
    localparam logic [4:0] EXP_MIN          = 5'h14;
    localparam logic [4:0] EXP_MAX          = 5'h1C;

    // ******************************************************************
    // values after reset, before a nonvolatile restore
    // ******************************************************************
    localparam logic [7:0] VEND_MASK_RST    = 8'hCE;
    localparam logic [7:0] VOUT_FORMAT_RST  = 8'h17;

    // ******************************************************************
    // conversion walk
    // ******************************************************************
    localparam int         NUM_VOUT_CMDS    = 4;

    typedef enum logic [1:0] {
        PMAF_IDLE  = 2'h0,
        PMAF_FETCH = 2'h1,
        PMAF_STORE = 2'h3
    } pmaf_conv_state_t;
endpackage : pmaf_pkg

// >>> verilog/pmaf_rescale.sv
`timescale 1ns/100ps
`default_nettype none
module pmaf_rescale (
    // value in old format
    input  wire logic [15:0] val_i,
    input  wire logic [4:0]  old_exp_i,
    input  wire logic [4:0]  new_exp_i,
    // value in new format
    output logic      [15:0] val_o
);
    logic signed [5:0]  diff;
    logic        [31:0] wide;
    logic        [3:0]  amt;

    always_comb begin
        diff = $signed({old_exp_i[4], old_exp_i}) -
               $signed({new_exp_i[4], new_exp_i});
        amt  = diff[5] ? 4'((~diff) + 6'h01) : diff[3:0];
        wide = {16'h0000, val_i};
        if (diff[5]) begin
            // coarser lsb: low bits are dropped, not rounded
            wide = wide >> amt;
        end else begin
            wide = wide << amt;
        end
        // finer lsb may overflow: saturate rather than wrap
        val_o = (wide[31:16] != 16'h0000) ? 16'hFFFF : wide[15:0];
    end
endmodule : pmaf_rescale
`default_nettype wire

// >>> verilog/pmaf_regs.sv
// Functional notes
// - misc alert mask sits at shared mask code with its own sub-code.
// - vendor alert mask sits at the same code with another sub-code.
// - misc mask reads 01h; bit 0 is fixed at one, others zero.
// - first-alerter condition alone never pulls the alert line.
// - vendor mask bits 7,6,3,2,1 writable; zero allows, one blocks.
// - vendor mask bits 5,4,0 read as zero.
// - clearing self-check mask may give alert at power-up.
// - clearing sync mask may pulse alert when stack is enabled.
// - format byte uses byte write and byte read; nonvolatile backed.
// - format byte ignores writes while conversion runs.
// - format byte: bit 7 relative flag, 6:5 read-only, 4:0 parameter.
// - format field reads 00b; exponent held between -4 and -12.
// - format write that changes the exponent rescales stored output-voltage command values.
`timescale 1ns/100ps
`default_nettype none
module pmaf_regs
    import pmaf_pkg::*;
#(
    parameter int NUM_CMDS = pmaf_pkg::NUM_VOUT_CMDS
) (
    // clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  reset_n_i,
    // decoded write transaction
    input  wire logic                  wr_i,
    input  wire logic [7:0]            wr_cmd_i,
    input  wire logic [7:0]            wr_sub_i,
    input  wire logic [7:0]            wr_data_i,
    // decoded read transaction
    input  wire logic                  rd_i,
    input  wire logic [7:0]            rd_cmd_i,
    input  wire logic [7:0]            rd_sub_i,
    output logic      [7:0]            rd_data_o,
    output logic                       rd_valid_o,
    output logic                       rd_unsup_o,
    output logic                       wr_refused_o,
    // nonvolatile restore
    input  wire logic                  nvm_load_i,
    input  wire logic [7:0]            nvm_vend_mask_i,
    input  wire logic [7:0]            nvm_format_i,
    // device state
    input  wire logic                  pwr_conv_on_i,
    input  wire logic [7:0]            misc_status_i,
    input  wire logic [7:0]            vend_status_i,
    // alert pin, open drain
    output logic                       smbalert_o,
    output logic                       smbalert_oe_o,
    // stored voltage command walk
    output logic                       conv_rd_o,
    output logic                       conv_we_o,
    output logic [$clog2(NUM_CMDS+1)-1:0] conv_idx_o,
    input  wire logic [15:0]           conv_val_i,
    output logic      [15:0]           conv_val_o,
    output logic                       conv_busy_o,
    // format as applied
    output logic      [7:0]            vout_format_o
);
    import pmaf_pkg::*;

    localparam int IW = $clog2(NUM_CMDS + 1);

    // refused at elaboration: the walk needs at least one stored command
    if (NUM_CMDS < 1) begin : g_bad_num_cmds
        $error("NUM_CMDS must be at least one");
    end

    // ******************************************************************
    // helpers
    // ******************************************************************
    function automatic logic is_mask(input logic [7:0] cmd,
                                     input logic [7:0] sub,
                                     input logic [7:0] want);
        is_mask = (cmd == CMD_ALERT_MASK) && (sub == want);
    endfunction : is_mask

    function automatic logic [7:0] fmt_clean(input logic [7:0] b);
        fmt_clean = {b[FMT_REL_BIT], FMT_LINEAR, b[4:0]};
    endfunction : fmt_clean

    function automatic logic exp_ok(input logic [7:0] b);
        exp_ok = (b[4:0] >= EXP_MIN) && (b[4:0] <= EXP_MAX);
    endfunction : exp_ok

    // ******************************************************************
    // register state
    // ******************************************************************
    logic [7:0]       vend_mask_r;
    logic [7:0]       format_r;
    logic [4:0]       old_exp_r;
    pmaf_conv_state_t state_r;
    logic [IW-1:0]    idx_r;
    logic [15:0]      conv_val_r;
    logic [15:0]      scaled;
    logic             fmt_wr;
    logic             fmt_take;

    assign fmt_wr   = wr_i && (wr_cmd_i == CMD_VOUT_FORMAT);
    // refused while converting power, walking, or exponent out of range;
    // a restore in the same cycle wins, so the write must not start a walk
    assign fmt_take = fmt_wr && !pwr_conv_on_i
                      && !nvm_load_i
                      && (state_r == PMAF_IDLE)
                      && exp_ok(wr_data_i);

    // ******************************************************************
    // vendor mask
    // ******************************************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vend_mask_r <= VEND_MASK_RST;
        end else if (nvm_load_i) begin
            vend_mask_r <= nvm_vend_mask_i & VEND_MASK_WR;
        end else if (wr_i && is_mask(wr_cmd_i, wr_sub_i,
                                     SUB_VEND_STATUS)) begin
            vend_mask_r <= wr_data_i & VEND_MASK_WR;
        end
    end

    // ******************************************************************
    // format byte
    // ******************************************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            format_r  <= VOUT_FORMAT_RST;
            old_exp_r <= VOUT_FORMAT_RST[4:0];
        end else if (nvm_load_i && exp_ok(nvm_format_i)) begin
            format_r  <= fmt_clean(nvm_format_i);
            old_exp_r <= nvm_format_i[4:0];
        end else if (fmt_take) begin
            format_r  <= fmt_clean(wr_data_i);
            old_exp_r <= format_r[4:0];
        end
    end

    // ******************************************************************
    // refusal report
    // ******************************************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_refused_o <= 1'b0;
        end else begin
            // a write to the fixed misc mask is also refused
            wr_refused_o <= (fmt_wr && !fmt_take) ||
                (wr_i && is_mask(wr_cmd_i, wr_sub_i, SUB_MISC_STATUS));
        end
    end

    // ******************************************************************
    // read path
    // ******************************************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
            rd_unsup_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_i;
            rd_unsup_o <= 1'b0;
            if (rd_i) begin
                if (is_mask(rd_cmd_i, rd_sub_i, SUB_MISC_STATUS)) begin
                    rd_data_o <= MISC_MASK_VALUE;
                end else if (is_mask(rd_cmd_i, rd_sub_i,
                                     SUB_VEND_STATUS)) begin
                    rd_data_o <= vend_mask_r;
                end else if (rd_cmd_i == CMD_VOUT_FORMAT) begin
                    rd_data_o <= format_r;
                end else begin
                    rd_data_o  <= 8'h00;
                    rd_unsup_o <= 1'b1;
                end
            end
        end
    end

    // ******************************************************************
    // alert line
    // ******************************************************************
    logic alert_nxt;

    // self-check and sync sources pass when unmasked; their power-up and
    // stack-enable glitches are the host's to mask
    assign alert_nxt =
        (|(vend_status_i & ~vend_mask_r & VEND_MASK_WR)) ||
        (|(misc_status_i & ~MISC_MASK_VALUE));

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            smbalert_oe_o <= 1'b0;
        end else begin
            smbalert_oe_o <= alert_nxt;
        end
    end

    assign smbalert_o = 1'b0;

    // ******************************************************************
    // conversion walk over stored voltage commands
    // ******************************************************************
    pmaf_rescale u_rescale (
        .val_i     (conv_val_i),
        .old_exp_i (old_exp_r),
        .new_exp_i (format_r[4:0]),
        .val_o     (scaled)
    );

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= PMAF_IDLE;
            idx_r   <= '0;
        end else begin
            case (state_r)
                PMAF_IDLE: begin
                    // only an exponent change needs a rescale
                    if (fmt_take && wr_data_i[4:0] != format_r[4:0]) begin
                        state_r <= PMAF_FETCH;
                        idx_r   <= '0;
                    end
                end
                PMAF_FETCH: begin
                    state_r <= PMAF_STORE;
                end
                PMAF_STORE: begin
                    if (idx_r == IW'(NUM_CMDS - 1)) begin
                        state_r <= PMAF_IDLE;
                    end else begin
                        state_r <= PMAF_FETCH;
                    end
                    idx_r <= idx_r + IW'(1);
                end
                default: begin
                    state_r <= PMAF_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_val_r <= 16'h0000;
        end else if (state_r == PMAF_FETCH) begin
            conv_val_r <= scaled;
        end
    end

    assign conv_rd_o     = (state_r == PMAF_FETCH);
    assign conv_we_o     = (state_r == PMAF_STORE);
    assign conv_idx_o    = idx_r;
    assign conv_val_o    = conv_val_r;
    assign conv_busy_o   = (state_r != PMAF_IDLE);
    assign vout_format_o = format_r;
endmodule : pmaf_regs
`default_nettype wire

// >>> tb/pmaf_vcmd_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// stored output-voltage command words
// ****
module pmaf_vcmd_model (
    // walk from the format logic
    input  wire logic        mclk_i,
    input  wire logic        rd_i,
    input  wire logic        we_i,
    input  wire logic [2:0]  idx_i,
    input  wire logic [15:0] val_i,
    // old value back
    output logic      [15:0] val_o
);
    logic [15:0] mem [4];
    initial begin
        mem = '{16'h0100, 16'h2000, 16'hFFFF, 16'h0001};
    end
    // outside a fetch the bus carries junk, so a late sample shows
    assign val_o = rd_i ? mem[idx_i] : ~mem[idx_i];
    always @(posedge mclk_i) begin
        if (we_i) begin
            mem[idx_i] <= val_i;
        end
    end
endmodule : pmaf_vcmd_model
`default_nettype wire

// >>> tb/pmaf_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module pmaf_regs_monitor #(
    parameter int NUM_CMDS = 4
) (
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    input wire logic       wr_i,
    input wire logic [7:0] wr_cmd_i,
    input wire logic [7:0] wr_sub_i,
    input wire logic [7:0] wr_data_i,
    input wire logic       rd_i,
    input wire logic [7:0] rd_cmd_i,
    input wire logic [7:0] rd_sub_i,
    input wire logic [7:0] rd_data_o,
    input wire logic       rd_valid_o,
    input wire logic       wr_refused_o,
    input wire logic       nvm_load_i,
    input wire logic       pwr_conv_on_i,
    input wire logic [7:0] misc_status_i,
    input wire logic [7:0] vend_status_i,
    input wire logic       smbalert_oe_o,
    input wire logic       conv_we_o,
    input wire logic [$clog2(NUM_CMDS+1)-1:0] conv_idx_o,
    input wire logic       conv_busy_o,
    input wire logic [7:0] vout_format_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    logic fw;
    // a restore in the same cycle wins, so it is kept out
    assign fw = wr_i && wr_cmd_i == 8'h20 && !nvm_load_i;
    a_misc_read: assert property (
        rd_i && rd_cmd_i == 8'h1B && rd_sub_i == 8'h7F
        |=> rd_valid_o && rd_data_o == 8'h01) else $error("misc mask read");
    a_vend_zero_bits: assert property (
        rd_i && rd_cmd_i == 8'h1B && rd_sub_i == 8'h80
        |=> rd_valid_o && (rd_data_o & 8'h31) == 8'h00)
        else $error("vend bits");
    a_misc_wr_refused: assert property (
        wr_i && wr_cmd_i == 8'h1B && wr_sub_i == 8'h7F && !nvm_load_i
        |=> wr_refused_o) else $error("misc write taken");
    a_fmt_locked: assert property (
        fw && pwr_conv_on_i |=> wr_refused_o && $stable(vout_format_o))
        else $error("format changed while locked");
    a_fmt_apply: assert property (
        fw && !pwr_conv_on_i && !conv_busy_o
        && wr_data_i[4:0] inside {[5'h14:5'h1C]} |=> vout_format_o
        == {$past(wr_data_i[7]), 2'b00, $past(wr_data_i[4:0])})
        else $error("format write lost");
    a_bad_exp: assert property (
        fw && !(wr_data_i[4:0] inside {[5'h14:5'h1C]})
        |=> wr_refused_o && $stable(vout_format_o))
        else $error("bad exponent");
    a_fmt_field: assert property (
        vout_format_o[6:5] == 2'b00
        && vout_format_o[4:0] inside {[5'h14:5'h1C]})
        else $error("format field");
    a_first_alone: assert property (
        misc_status_i == 8'h01 && vend_status_i == 8'h00 |=> !smbalert_oe_o)
        else $error("first alerter drove alert");
    a_misc_alert: assert property (
        |(misc_status_i & 8'hFE) |=> smbalert_oe_o)
        else $error("alert missing");
    a_walk_end: assert property (
        $fell(conv_busy_o) |-> $past(conv_we_o)
        && $past(conv_idx_o) == NUM_CMDS - 1) else $error("walk short");
endmodule : pmaf_regs_monitor
bind pmaf_regs pmaf_regs_monitor #(.NUM_CMDS(NUM_CMDS)) pmaf_regs_monitor_inst (
    .mclk_i, .reset_n_i, .wr_i, .wr_cmd_i, .wr_sub_i, .wr_data_i, .rd_i,
    .rd_cmd_i, .rd_sub_i, .rd_data_o, .rd_valid_o, .wr_refused_o, .nvm_load_i,
    .pwr_conv_on_i, .misc_status_i, .vend_status_i, .smbalert_oe_o,
    .conv_we_o, .conv_idx_o, .conv_busy_o, .vout_format_o);
`default_nettype wire

// >>> tb/pmaf_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module pmaf_regs_tb_top;
    import pmaf_pkg::*;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0, refused;
    logic        wr_i = 1'b0, rd_i = 1'b0, nvm_load_i = 1'b0;
    logic        pwr_conv_on_i = 1'b0;
    logic [7:0]  wr_cmd_i = '0, wr_sub_i = '0, wr_data_i = '0;
    logic [7:0]  rd_cmd_i = '0, rd_sub_i = '0, misc_status_i = '0;
    logic [7:0]  vend_status_i = '0, nvm_vend_mask_i = '0, nvm_format_i = '0;
    logic [7:0]  rd_data_o, vout_format_o;
    logic        rd_valid_o, rd_unsup_o, wr_refused_o, smbalert_o;
    logic        smbalert_oe_o, conv_rd_o, conv_we_o, conv_busy_o;
    logic [2:0]  conv_idx_o;
    logic [15:0] conv_val_i, conv_val_o;
    int          bad_count = 0, checked = 0;
    pmaf_regs #(.NUM_CMDS(4)) pmaf_regs_inst (.mclk_i, .reset_n_i, .wr_i,
        .wr_cmd_i, .wr_sub_i, .wr_data_i, .rd_i, .rd_cmd_i, .rd_sub_i,
        .rd_data_o, .rd_valid_o, .rd_unsup_o, .wr_refused_o, .nvm_load_i,
        .nvm_vend_mask_i, .nvm_format_i, .pwr_conv_on_i, .misc_status_i,
        .vend_status_i, .smbalert_o, .smbalert_oe_o, .conv_rd_o, .conv_we_o,
        .conv_idx_o, .conv_val_i, .conv_val_o, .conv_busy_o, .vout_format_o);
    pmaf_vcmd_model pmaf_vcmd_model_inst (.mclk_i, .rd_i(conv_rd_o),
        .we_i(conv_we_o), .idx_i(conv_idx_o), .val_i(conv_val_o),
        .val_o(conv_val_i));
    always #20 mclk_i = ~mclk_i;
    // ****
    // transactions, driven on the falling edge
    // ****
    task automatic wr(input logic [7:0] c, s, d);
        @(negedge mclk_i);
        {wr_i, wr_cmd_i, wr_sub_i, wr_data_i} = {1'b1, c, s, d};
        @(negedge mclk_i);
        wr_i = 1'b0;
        refused = wr_refused_o;
    endtask : wr
    task automatic rd(input logic [7:0] c, s, e, input string n);
        @(negedge mclk_i);
        {rd_i, rd_cmd_i, rd_sub_i} = {1'b1, c, s};
        @(negedge mclk_i);
        rd_i = 1'b0;
        `CHK("rd_valid", 1'b1, rd_valid_o)
        `CHK(n, e, rd_data_o)
    endtask : rd
    task automatic alert(input logic [7:0] v, m, input logic e);
        @(negedge mclk_i);
        vend_status_i = v;
        misc_status_i = m;
        @(negedge mclk_i);
        `CHK("alert_oe", e, smbalert_oe_o)
        `CHK("alert_pin", 1'b0, smbalert_o)
    endtask : alert
    task automatic walk_done();
        int k;
        for (k = 0; k < 40 && conv_busy_o !== 1'b0; k++) @(negedge mclk_i);
        if (k == 40) begin
            bad_count++;
            complete_run();
        end
    endtask : walk_done
    task automatic complete_run();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    // ****
    // sequence
    // ****
    initial begin
        repeat (5) @(negedge mclk_i);
        reset_n_i = 1'b1;
        rd(8'h1B, 8'h80, 8'hCE, "vend_mask");
        rd(8'h20, 8'h00, 8'h17, "format");
        wr(8'h1B, 8'h7F, 8'h00);
        `CHK("misc_refused", 1'b1, refused)
        rd(8'h1B, 8'h7F, 8'h01, "misc_mask");
        `CHK("misc_unsup", 1'b0, rd_unsup_o)
        rd(8'h1B, 8'h7E, 8'h00, "other_mask");
        `CHK("other_unsup", 1'b1, rd_unsup_o)
        $display("test reset_and_misc done");
        wr(8'h1B, 8'h80, 8'hFF);
        rd(8'h1B, 8'h80, 8'hCE, "vend_mask");
        wr(8'h1B, 8'h80, 8'h00);
        rd(8'h1B, 8'h80, 8'h00, "vend_mask");
        for (int b = 0; b < 8; b++) begin
            alert(8'h01 << b, 8'h00, VEND_MASK_WR[b]);
            wr(8'h1B, 8'h80, 8'h01 << b);
            alert(8'h01 << b, 8'h00, 1'b0);
            wr(8'h1B, 8'h80, 8'h00);
        end
        alert(8'h00, 8'h01, 1'b0);
        alert(8'h00, 8'h80, 1'b1);
        alert(8'h00, 8'h00, 1'b0);
        $display("test alert done");
        wr(8'h20, 8'h00, 8'hF3);
        `CHK("exp_low", 1'b1, refused)
        wr(8'h20, 8'h00, 8'h1D);
        `CHK("exp_high", 1'b1, refused)
        wr(8'h20, 8'h00, 8'hF4);
        walk_done();
        rd(8'h20, 8'h00, 8'h94, "format");
        `CHK("cmd0", 16'h0800, pmaf_vcmd_model_inst.mem[0])
        `CHK("cmd1", 16'hFFFF, pmaf_vcmd_model_inst.mem[1])
        wr(8'h20, 8'h00, 8'h14);
        `CHK("rel_walk", 1'b0, conv_busy_o)
        wr(8'h20, 8'h00, 8'h1C);
        walk_done();
        `CHK("cmd0", 16'h0008, pmaf_vcmd_model_inst.mem[0])
        pwr_conv_on_i = 1'b1;
        wr(8'h20, 8'h00, 8'h17);
        `CHK("locked", 1'b1, refused)
        rd(8'h20, 8'h00, 8'h1C, "format");
        pwr_conv_on_i = 1'b0;
        $display("test format done");
        {nvm_load_i, nvm_vend_mask_i, nvm_format_i} = {1'b1, 8'hFF, 8'h1A};
        @(negedge mclk_i);
        nvm_load_i = 1'b0;
        walk_done();
        rd(8'h1B, 8'h80, 8'hCE, "vend_mask");
        rd(8'h20, 8'h00, 8'h1A, "format");
        reset_n_i = 1'b0;
        @(negedge mclk_i);
        reset_n_i = 1'b1;
        rd(8'h20, 8'h00, 8'h17, "format");
        $display("test restore done");
        complete_run();
    end
endmodule : pmaf_regs_tb_top
`default_nettype wire
